// >>> design/llc_pkg.sv
// Package of constants for the LED lighting controller
// Notes on behaviour
// (RL1) Halo colour = global*brightness/250*colour/250
// (RL2) Symbol = global*brightness/250, no colour factor
// (RL3) Raise brightness below minimum to that minimum
// (RL4) Pattern codes: steady, pulsate, rotate per group
// (RL5) Slow flash: on time, then period minus on
// (RL6) Fast flash: on time, then period minus on
// (RL7) Halo LED needs ring and LED enable
// (RL8) Host enables ring, then masks single LEDs
// (RL9) Symbol output zero when its enable clear
// (RL10) Halo picks one of four colour settings
// (RL11) Halo and symbol pick one of three brightnesses
// (RL12) Final brightness drives that LED's PWM output
// (RL13) Communication timeout exists under J1939 only
// (RL14) Missing keep-alive: halos flash white
// (RL15) Timeout entry switches LED enables off
// (RL16) Host keep-alives end and prevent timeout
// (RL17) Timeout length programmable, two seconds default
// (RL18) Pulsate ramps, rotate walks the four LEDs
// (RL19) Order: product, clamp, pattern, enables
`default_nettype none
package llc_pkg;
  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BTN       = 6;
  localparam int unsigned LEDS_PER_HALO = 4;
  localparam int unsigned NUM_HALO_CH   = NUM_BTN * LEDS_PER_HALO * 3;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  PWM_TOP       = 8'hfe;
  localparam logic [23:0] BRI_DIV       = 24'h0000fa;
  localparam logic [7:0]  WHITE_LEVEL   = 8'hfa;
  // ----------------------------------------------------------------
  // Temporal pattern codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PAT_STEADY = 3'h0;
  localparam logic [2:0] PAT_SLOW   = 3'h1;
  localparam logic [2:0] PAT_FAST   = 3'h2;
  localparam logic [2:0] PAT_PULSE  = 3'h3;
  localparam logic [2:0] PAT_ROTATE = 3'h4;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_GLOBAL   = 12'h004;
  localparam logic [11:0] OFS_SLOW     = 12'h008;
  localparam logic [11:0] OFS_FAST     = 12'h00c;
  localparam logic [11:0] OFS_HALO_PAT = 12'h010;
  localparam logic [11:0] OFS_SYM_PAT  = 12'h014;
  localparam logic [11:0] OFS_BSEL     = 12'h018;
  localparam logic [11:0] OFS_CSEL     = 12'h01c;
  localparam logic [11:0] OFS_ENABLE   = 12'h020;
  localparam logic [11:0] OFS_LED_EN   = 12'h024;
  localparam logic [11:0] OFS_TIMEOUT  = 12'h028;
  localparam logic [11:0] OFS_STATUS   = 12'h02c;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h030;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h034;
  localparam logic [11:0] OFS_HALO_BRI = 12'h100;
  localparam logic [11:0] OFS_SYM_BRI  = 12'h120;
  localparam logic [11:0] OFS_COLOUR   = 12'h140;
  localparam logic [11:0] OFS_COL_END  = 12'h1a0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SLOW_ON  = 16'h01f4;
  localparam logic [15:0] RST_SLOW_PER = 16'h03e8;
  localparam logic [15:0] RST_FAST_ON  = 16'h0064;
  localparam logic [15:0] RST_FAST_PER = 16'h00c8;
  localparam logic [7:0]  RST_GLOBAL   = 8'hfa;
  localparam logic [15:0] RST_TIMEOUT  = 16'h07d0;
endpackage
`default_nettype wire

// >>> design/llc_flash_timer.sv
// Flash phase timer counting milliseconds within one flash period
`timescale 1ns/1ps
`default_nettype none
module llc_flash_timer (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // Timing
  input  wire logic        i_tick,
  input  wire logic [15:0] i_on_ms,
  input  wire logic [15:0] i_period_ms,
  // Phase
  output logic             o_on
);
  typedef struct packed {
    logic [15:0] cnt;
  } llc_ft_state_t;

  llc_ft_state_t st;
  llc_ft_state_t next_st;

  always_comb begin
    next_st = st;
    if (i_tick) begin
      // A shortened period restarts the count instead of running away
      if (st.cnt + 16'h0001 >= i_period_ms) begin
        next_st.cnt = 16'h0000; // RL5 RL6
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_on = st.cnt < i_on_ms; // RL5 RL6
endmodule
`default_nettype wire

// >>> design/llc_led_chan.sv
// Brightness path of one LED channel, from settings to PWM duty
`timescale 1ns/1ps
`default_nettype none
module llc_led_chan (
  // Settings
  input  wire logic [7:0] i_glob,
  input  wire logic [7:0] i_bri,
  input  wire logic [7:0] i_col,
  input  wire logic       i_use_col,
  input  wire logic [7:0] i_min,
  input  wire logic [2:0] i_pat,
  // Pattern sources
  input  wire logic       i_slow_on,
  input  wire logic       i_fast_on,
  input  wire logic [7:0] i_pulse_f,
  input  wire logic [7:0] i_rot_f,
  input  wire logic       i_enable,
  // Result
  output logic [7:0]      o_duty
);
  localparam logic [23:0] BRI_DIV_SQ = 24'(llc_pkg::BRI_DIV * llc_pkg::BRI_DIV);

  logic [23:0] prod;
  logic [15:0] scaled;
  logic [7:0]  base;
  logic [7:0]  clamped;
  logic [7:0]  shaped;

  always_comb begin
    prod = 24'(i_glob) * 24'(i_bri);
    // Full-scale settings overshoot slightly, so the result saturates
    if (i_use_col) begin
      prod = (prod * 24'(i_col)) / (BRI_DIV_SQ); // RL1
    end else begin
      prod = prod / llc_pkg::BRI_DIV; // RL2
    end
    base    = (prod > 24'h0000ff) ? 8'hff : prod[7:0];
    clamped = (base > i_min) ? base : i_min; // RL3 RL19
    scaled  = 16'h0000;
    case (i_pat)
      llc_pkg::PAT_STEADY: shaped = clamped; // RL4
      llc_pkg::PAT_SLOW:   shaped = i_slow_on ? clamped : 8'h00; // RL5
      llc_pkg::PAT_FAST:   shaped = i_fast_on ? clamped : 8'h00; // RL6
      llc_pkg::PAT_PULSE: begin
        scaled = 16'(clamped) * 16'(i_pulse_f); // RL4 RL18
        shaped = scaled[15:8];
      end
      llc_pkg::PAT_ROTATE: begin
        scaled = 16'(clamped) * 16'(i_rot_f); // RL4 RL18
        shaped = scaled[15:8];
      end
      default:             shaped = clamped;
    endcase
    o_duty = i_enable ? shaped : 8'h00; // RL7 RL9 RL19
  end
endmodule
`default_nettype wire

// >>> design/llc_top.sv
// LED lighting controller top: APB registers, timeout monitor, PWM
`timescale 1ns/1ps
`default_nettype none
module llc_top #(
  parameter int unsigned MS_CYCLES = llc_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Keep-alive from the protocol stack
  input  wire logic        i_prop_a_rx,
  // LED drive
  output logic [71:0]      o_halo_pwm,
  output logic [5:0]       o_sym_pwm,
  // Interrupt
  output logic             o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              j1939;
    logic [7:0]        glob_halo;
    logic [7:0]        glob_sym;
    logic [7:0]        minimum;
    logic [15:0]       slow_on;
    logic [15:0]       slow_per;
    logic [15:0]       fast_on;
    logic [15:0]       fast_per;
    logic [5:0][2:0]   halo_pat;
    logic [5:0][2:0]   sym_pat;
    logic [5:0][1:0]   halo_bsel;
    logic [5:0][1:0]   sym_bsel;
    logic [5:0][1:0]   col_sel;
    logic [5:0]        sym_en;
    logic [5:0]        ring_en;
    logic [23:0]       led_en;
    logic [15:0]       to_limit;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic [5:0][23:0]  halo_bri;
    logic [5:0][23:0]  sym_bri;
    logic [23:0][23:0] colour;
    logic [13:0]       ms_cnt;
    logic [15:0]       to_cnt;
    logic [8:0]        pulse_cnt;
    logic              timeout;
    logic [7:0]        pwm_cnt;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              irq;
    logic [71:0]       halo_pwm;
    logic [5:0]        sym_pwm;
  } llc_state_t;

  llc_state_t st;
  llc_state_t next_st;

  logic             tick;
  logic             slow_on;
  logic             fast_on;
  logic [7:0]       pulse_f;
  logic [1:0]       rot_pos;
  logic [71:0][7:0] halo_duty;
  logic [5:0][7:0]  sym_duty;
  logic             wr_en;
  logic [4:0]       col_idx;
  logic [11:0]      col_ofs;

  assign tick    = st.ms_cnt == 14'(MS_CYCLES - 1);
  assign pulse_f = st.pulse_cnt[8] ? ~st.pulse_cnt[7:0] : st.pulse_cnt[7:0]; // RL18
  assign rot_pos = st.pulse_cnt[8:7]; // RL18
  assign wr_en   = i_psel & i_penable & st.pready & i_pwrite;
  assign col_ofs = i_paddr - llc_pkg::OFS_COLOUR;
  assign col_idx = col_ofs[6:2];

  // ----------------------------------------------------------------
  // Flash timers
  // ----------------------------------------------------------------
  llc_flash_timer u_slow (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_tick      (tick),
    .i_on_ms     (st.slow_on),
    .i_period_ms (st.slow_per),
    .o_on        (slow_on)
  );

  llc_flash_timer u_fast (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_tick      (tick),
    .i_on_ms     (st.fast_on),
    .i_period_ms (st.fast_per),
    .o_on        (fast_on)
  );

  // ----------------------------------------------------------------
  // Channel paths
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 78; g++) begin : g_chan
    localparam int unsigned BTN = (g < 72) ? g / 12 : g - 72;
    localparam int unsigned LED = (g / 3) % 4;
    localparam int unsigned RGB = g % 3;
    logic [1:0] bsel;
    logic [1:0] csel;
    logic [7:0] bri;
    logic [7:0] col;
    logic [7:0] duty;
    logic       halo_en;
    if (g < 72) begin : g_halo
      assign bsel    = (st.halo_bsel[BTN] == 2'h3) ? 2'h2 : st.halo_bsel[BTN]; // RL11
      assign csel    = st.col_sel[BTN]; // RL10
      assign bri     = st.halo_bri[BTN][8*bsel +: 8];
      assign col     = st.colour[BTN*4 + csel][8*RGB +: 8]; // RL10
      assign halo_en = st.ring_en[BTN] & st.led_en[BTN*4 + LED]; // RL7 RL8
      llc_led_chan u_chan (
        .i_glob    (st.glob_halo),
        .i_bri     (bri),
        .i_col     (col),
        .i_use_col (1'b1),
        .i_min     (st.minimum),
        .i_pat     (st.halo_pat[BTN]),
        .i_slow_on (slow_on),
        .i_fast_on (fast_on),
        .i_pulse_f (pulse_f),
        .i_rot_f   ((rot_pos == 2'(LED)) ? 8'hff : 8'h00),
        .i_enable  (halo_en),
        .o_duty    (duty)
      );
      // Timeout overrides every halo with plain white on the slow rhythm
      assign halo_duty[g] = st.timeout ? (slow_on ? llc_pkg::WHITE_LEVEL : 8'h00)
                                       : duty; // RL14
    end else begin : g_sym
      assign bsel    = (st.sym_bsel[BTN] == 2'h3) ? 2'h2 : st.sym_bsel[BTN]; // RL11
      assign csel    = 2'h0;
      assign col     = 8'h00;
      assign halo_en = 1'b0;
      assign bri     = st.sym_bri[BTN][8*bsel +: 8];
      llc_led_chan u_chan (
        .i_glob    (st.glob_sym),
        .i_bri     (bri),
        .i_col     (col),
        .i_use_col (1'b0),
        .i_min     (st.minimum),
        .i_pat     (st.sym_pat[BTN]),
        .i_slow_on (slow_on),
        .i_fast_on (fast_on),
        .i_pulse_f (pulse_f),
        .i_rot_f   (pulse_f),
        .i_enable  (st.sym_en[BTN]),
        .o_duty    (duty)
      );
      assign sym_duty[BTN] = duty; // RL9
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        hit;
    logic [31:0] rd;
    logic [1:0]  irq_set;
    hit     = 1'b1;
    rd      = 32'h00000000;
    irq_set = 2'h0;
    next_st = st;
    // Read data is captured in the setup cycle; ready follows one cycle later
    case (i_paddr)
      llc_pkg::OFS_CTRL:     rd = {31'h0, st.j1939};
      llc_pkg::OFS_GLOBAL:   rd = {8'h00, st.minimum, st.glob_sym, st.glob_halo};
      llc_pkg::OFS_SLOW:     rd = {st.slow_per, st.slow_on};
      llc_pkg::OFS_FAST:     rd = {st.fast_per, st.fast_on};
      llc_pkg::OFS_HALO_PAT: rd = {14'h0, st.halo_pat};
      llc_pkg::OFS_SYM_PAT:  rd = {14'h0, st.sym_pat};
      llc_pkg::OFS_BSEL:     rd = {8'h00, st.sym_bsel, st.halo_bsel};
      llc_pkg::OFS_CSEL:     rd = {20'h0, st.col_sel};
      llc_pkg::OFS_ENABLE:   rd = {18'h0, st.ring_en, 2'h0, st.sym_en};
      llc_pkg::OFS_LED_EN:   rd = {8'h00, st.led_en};
      llc_pkg::OFS_TIMEOUT:  rd = {16'h0, st.to_limit};
      llc_pkg::OFS_STATUS:   rd = {31'h0, st.timeout};
      llc_pkg::OFS_IRQ_STAT: rd = {30'h0, st.irq_stat};
      llc_pkg::OFS_IRQ_MASK: rd = {30'h0, st.irq_mask};
      default: begin
        if (i_paddr[11:5] == llc_pkg::OFS_HALO_BRI[11:5] && i_paddr[4:2] < 3'h6) begin
          rd = {8'h00, st.halo_bri[i_paddr[4:2]]};
        end else if (i_paddr[11:5] == llc_pkg::OFS_SYM_BRI[11:5] && i_paddr[4:2] < 3'h6) begin
          rd = {8'h00, st.sym_bri[i_paddr[4:2]]};
        end else if (i_paddr >= llc_pkg::OFS_COLOUR && i_paddr < llc_pkg::OFS_COL_END) begin
          rd = {8'h00, st.colour[col_idx]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    if (i_paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end
    next_st.pready  = i_psel & ~i_penable;
    next_st.pslverr = i_psel & ~i_penable & ~hit;
    if (i_psel & ~i_penable) begin
      next_st.prdata = hit ? rd : 32'h00000000;
    end
    if (wr_en & hit) begin
      case (i_paddr)
        llc_pkg::OFS_CTRL:     next_st.j1939 = i_pwdata[0];
        llc_pkg::OFS_GLOBAL: begin
          next_st.glob_halo = i_pwdata[7:0];
          next_st.glob_sym  = i_pwdata[15:8];
          next_st.minimum   = i_pwdata[23:16];
        end
        llc_pkg::OFS_SLOW:     {next_st.slow_per, next_st.slow_on} = i_pwdata;
        llc_pkg::OFS_FAST:     {next_st.fast_per, next_st.fast_on} = i_pwdata;
        llc_pkg::OFS_HALO_PAT: next_st.halo_pat = i_pwdata[17:0];
        llc_pkg::OFS_SYM_PAT:  next_st.sym_pat = i_pwdata[17:0];
        llc_pkg::OFS_BSEL:     {next_st.sym_bsel, next_st.halo_bsel} = i_pwdata[23:0];
        llc_pkg::OFS_CSEL:     next_st.col_sel = i_pwdata[11:0];
        llc_pkg::OFS_ENABLE: begin
          next_st.sym_en  = i_pwdata[5:0];
          next_st.ring_en = i_pwdata[13:8];
        end
        llc_pkg::OFS_LED_EN:   next_st.led_en = i_pwdata[23:0];
        llc_pkg::OFS_TIMEOUT:  next_st.to_limit = i_pwdata[15:0]; // RL17
        llc_pkg::OFS_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~i_pwdata[1:0];
        llc_pkg::OFS_IRQ_MASK: next_st.irq_mask = i_pwdata[1:0];
        default: begin
          if (i_paddr[11:5] == llc_pkg::OFS_HALO_BRI[11:5]) begin
            next_st.halo_bri[i_paddr[4:2]] = i_pwdata[23:0];
          end else if (i_paddr[11:5] == llc_pkg::OFS_SYM_BRI[11:5]) begin
            next_st.sym_bri[i_paddr[4:2]] = i_pwdata[23:0];
          end else if (i_paddr >= llc_pkg::OFS_COLOUR) begin
            next_st.colour[col_idx] = i_pwdata[23:0];
          end
        end
      endcase
    end
    // Millisecond base for flash, pulsate, rotate and timeout
    next_st.ms_cnt = tick ? 14'h0000 : st.ms_cnt + 14'h0001;
    if (tick) begin
      next_st.pulse_cnt = st.pulse_cnt + 9'h001;
    end
    // Timeout monitor; it runs after the bus write so its clear wins
    if (!st.j1939) begin
      next_st.timeout = 1'b0; // RL13
      next_st.to_cnt  = 16'h0000;
    end else if (i_prop_a_rx) begin
      next_st.to_cnt  = 16'h0000; // RL16
      next_st.timeout = 1'b0;
      irq_set[1]      = st.timeout;
    end else if (tick && !st.timeout) begin
      if (st.to_cnt + 16'h0001 >= st.to_limit) begin
        next_st.timeout = 1'b1; // RL14
        next_st.sym_en  = 6'h00; // RL15
        next_st.ring_en = 6'h00; // RL15
        next_st.led_en  = 24'h000000; // RL15
        irq_set[0]      = 1'b1;
      end else begin
        next_st.to_cnt = st.to_cnt + 16'h0001;
      end
    end
    next_st.irq_stat = next_st.irq_stat | irq_set;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    // PWM carrier; a duty of 0xff keeps the output on throughout
    next_st.pwm_cnt = (st.pwm_cnt == llc_pkg::PWM_TOP) ? 8'h00 : st.pwm_cnt + 8'h01;
    for (int i = 0; i < 72; i++) begin
      next_st.halo_pwm[i] = st.pwm_cnt < halo_duty[i]; // RL12
    end
    for (int i = 0; i < 6; i++) begin
      next_st.sym_pwm[i] = st.pwm_cnt < sym_duty[i]; // RL12
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st           <= '0;
      st.j1939     <= 1'b1;
      st.glob_halo <= llc_pkg::RST_GLOBAL;
      st.glob_sym  <= llc_pkg::RST_GLOBAL;
      st.slow_on   <= llc_pkg::RST_SLOW_ON;
      st.slow_per  <= llc_pkg::RST_SLOW_PER;
      st.fast_on   <= llc_pkg::RST_FAST_ON;
      st.fast_per  <= llc_pkg::RST_FAST_PER;
      st.to_limit  <= llc_pkg::RST_TIMEOUT; // RL17
    end else begin
      st <= next_st;
    end
  end

  assign o_pready   = st.pready;
  assign o_prdata   = st.prdata;
  assign o_pslverr  = st.pslverr;
  assign o_halo_pwm = st.halo_pwm;
  assign o_sym_pwm  = st.sym_pwm;
  assign o_irq      = st.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RING_GATE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL7
    (!st.ring_en[0] && !st.timeout) |-> halo_duty[0] == 8'h00)
    else $error("halo output live with ring disabled");
  AST_SYM_GATE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL9
    !st.sym_en[0] |=> !o_sym_pwm[0])
    else $error("symbol pwm high while disabled");
  AST_MIN_CLAMP: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL3
    (st.sym_en[0] && st.sym_pat[0] == llc_pkg::PAT_STEADY) |-> sym_duty[0] >= st.minimum)
    else $error("symbol duty below minimum");
  AST_SLOW_OFF: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL5
    (st.sym_pat[0] == llc_pkg::PAT_SLOW && !slow_on) |-> sym_duty[0] == 8'h00)
    else $error("slow flash not dark in off phase");
  AST_FAST_OFF: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL6
    (st.sym_pat[0] == llc_pkg::PAT_FAST && !fast_on) |-> sym_duty[0] == 8'h00)
    else $error("fast flash not dark in off phase");
  AST_PWM_FULL: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL12
    (sym_duty[0] == 8'hff) [*2] |=> o_sym_pwm[0])
    else $error("full duty did not hold pwm high");
  AST_CANOPEN_NO_TO: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL13
    !st.j1939 |=> !st.timeout)
    else $error("timeout active outside J1939");
  AST_TO_ENTER: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL14
    (st.j1939 && !st.timeout && tick && !i_prop_a_rx && st.to_cnt + 16'h0001 >= st.to_limit)
    |=> st.timeout)
    else $error("timeout not entered at limit");
  AST_TO_OFF: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL15
    $rose(st.timeout) |-> (st.sym_en == 6'h00 && st.ring_en == 6'h00 && st.led_en == 24'h0))
    else $error("LED enables not cleared on timeout");
  AST_TO_LEAVE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL16
    (st.j1939 && st.timeout && i_prop_a_rx) |=> !st.timeout ##0 st.irq_stat[1])
    else $error("keep-alive did not end timeout");
  AST_LIMIT_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL17
    $changed(st.to_limit) |-> $past(wr_en))
    else $error("timeout length changed without a write");
endmodule
`default_nettype wire

// >>> verif/llc_host.sv
// Host model: APB master writing lighting settings, keep-alive source
`timescale 1ns/1ps
`default_nettype none
module llc_host (
  // Bus
  input  wire logic        i_ref_clk,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr,
  // Keep-alive
  output logic             o_prop_a
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0;
    o_prop_a  = 1'b0;
  end
  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge i_ref_clk);
    o_psel   <= 1'b1;
    o_pwrite <= w;
    o_paddr  <= a;
    o_pwdata <= d;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 50);
    q = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // Released lines must not keep looking valid
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
    if (n >= 50) begin
      llc_top_tb_top.bad_count++;
      llc_top_tb_top.results();
    end
  endtask
  // Keep-alive restarts communication
  task automatic ping;
    @(posedge i_ref_clk);
    o_prop_a <= 1'b1;
    @(posedge i_ref_clk);
    o_prop_a <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/llc_top_tb_top.sv
// Testbench for the LED lighting controller
`timescale 1ns/1ps
`default_nettype none
module llc_top_tb_top;
  logic        i_ref_clk, i_reset, psel, pen, pwr, rdy, err, ka, irq;
  logic [11:0] adr;
  logic [31:0] wd, rdd;
  logic [71:0] halo;
  logic [5:0]  sym;
  wire  [77:0] pwm = {sym, halo};
  int          bad_count, num_checks, c;
  llc_top #(.MS_CYCLES(10)) DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(adr), .i_pwdata(wd),
    .o_pready(rdy), .o_prdata(rdd), .o_pslverr(err), .i_prop_a_rx(ka),
    .o_halo_pwm(halo), .o_sym_pwm(sym), .o_irq(irq));
  llc_host host (.i_ref_clk(i_ref_clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(adr), .o_pwdata(wd), .i_pready(rdy), .i_prdata(rdd), .i_pslverr(err),
    .o_prop_a(ka));
  always #50 i_ref_clk = ~i_ref_clk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        x;
    host.xfer(1'b1, a, d, q, x);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic        x;
    host.xfer(1'b0, a, 32'h0, q, x);
    chk(q, e);
    chk({31'h0, x}, {31'h0, ee});
  endtask
  // PWM count over whole periods, so phase does not matter
  task cnt(input int i, input int n, output int k);
    repeat (8) @(posedge i_ref_clk);
    k = 0;
    repeat (n) begin
      @(posedge i_ref_clk);
      k += pwm[i];
    end
  endtask
  task duty(input int i, input int n, input int e);
    cnt(i, n, c);
    chk(c, e);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    bad_count++;
    results();
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    i_reset   = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(llc_pkg::OFS_TIMEOUT, 32'h7d0, 1'b0);
    rd(llc_pkg::OFS_CTRL, 32'h1, 1'b0);
    rd(12'hffc, 32'h0, 1'b1);
    wr(llc_pkg::OFS_CTRL, 32'h0);
    wr(llc_pkg::OFS_TIMEOUT, 32'h3);
    $display("test registers done");
    wr(llc_pkg::OFS_GLOBAL, 32'h0000fafa);
    wr(llc_pkg::OFS_SYM_BRI, 32'h00ffc8fa);
    wr(llc_pkg::OFS_ENABLE, 32'h1);
    for (int s = 0; s < 3; s++) begin
      wr(llc_pkg::OFS_BSEL, s << 12);
      duty(72, 255, s == 0 ? 250 : s == 1 ? 200 : 255);
    end
    wr(llc_pkg::OFS_BSEL, 32'h1000);
    wr(llc_pkg::OFS_GLOBAL, 32'h00e6fafa);
    duty(72, 255, 230);
    wr(llc_pkg::OFS_GLOBAL, 32'h0000fafa);
    wr(llc_pkg::OFS_ENABLE, 32'h0);
    duty(72, 255, 0);
    $display("test symbol done");
    wr(llc_pkg::OFS_ENABLE, 32'h1);
    wr(llc_pkg::OFS_BSEL, 32'h2000);
    wr(llc_pkg::OFS_SLOW, 32'h00040002);
    wr(llc_pkg::OFS_FAST, 32'h00040001);
    wr(llc_pkg::OFS_SYM_PAT, 32'h1);
    duty(72, 400, 200);
    wr(llc_pkg::OFS_SYM_PAT, 32'h2);
    duty(72, 400, 100);
    for (int p = 3; p < 5; p++) begin
      wr(llc_pkg::OFS_SYM_PAT, p);
      cnt(72, 5120, c);
      chk(c > 0 && c < 5120, 1);
    end
    wr(llc_pkg::OFS_SYM_PAT, 32'h0);
    $display("test pattern done");
    wr(llc_pkg::OFS_HALO_BRI, 32'h00007d00);
    wr(llc_pkg::OFS_BSEL, 32'h1);
    wr(llc_pkg::OFS_CSEL, 32'h2);
    wr(llc_pkg::OFS_COLOUR + 12'h8, 32'h000064fa);
    wr(llc_pkg::OFS_ENABLE, 32'h100);
    wr(llc_pkg::OFS_LED_EN, 32'h1);
    for (int k = 0; k < 4; k++)
      duty(k, 255, k == 0 ? 125 : k == 1 ? 50 : 0);
    wr(llc_pkg::OFS_HALO_PAT, 32'h4);
    cnt(0, 5120, c);
    chk(c > 0 && c < 1280, 1);
    wr(llc_pkg::OFS_HALO_PAT, 32'h0);
    wr(llc_pkg::OFS_LED_EN, 32'hffffff);
    wr(llc_pkg::OFS_ENABLE, 32'h0);
    duty(0, 255, 0);
    rd(llc_pkg::OFS_STATUS, 32'h0, 1'b0);
    $display("test halo done");
    wr(llc_pkg::OFS_ENABLE, 32'h101);
    wr(llc_pkg::OFS_IRQ_MASK, 32'h1);
    host.ping();
    wr(llc_pkg::OFS_CTRL, 32'h1);
    c = 0;
    while (irq !== 1'b1 && c < 200) begin
      @(posedge i_ref_clk);
      c++;
    end
    chk(irq, 1);
    rd(llc_pkg::OFS_STATUS, 32'h1, 1'b0);
    rd(llc_pkg::OFS_ENABLE, 32'h0, 1'b0);
    rd(llc_pkg::OFS_HALO_BRI, 32'h7d00, 1'b0);
    cnt(0, 400, c);
    chk(c > 0, 1);
    host.ping();
    rd(llc_pkg::OFS_STATUS, 32'h0, 1'b0);
    rd(llc_pkg::OFS_IRQ_STAT, 32'h3, 1'b0);
    wr(llc_pkg::OFS_CTRL, 32'h0);
    wr(llc_pkg::OFS_IRQ_STAT, 32'h3);
    repeat (3) @(posedge i_ref_clk);
    chk(irq, 0);
    $display("test timeout done");
    results();
  end
endmodule
`default_nettype wire
